// ===== core/fsc_flag_enc.sv
`default_nettype none
module fsc_flag_enc
(
  fsc_flag_if.enc f
);
  // ----------------------------------------
  // result class encoding
  // ----------------------------------------
  logic [3:0] cc_one;
  always_comb
  begin
    cc_one = 4'h1;
    // a malformed compare code falls back to unordered
    case (f.cmp_cc)
      4'h8, 4'h4, 4'h2, 4'h1: cc_one = f.cmp_cc;
      default:                cc_one = 4'h1;
    endcase
    f.flags = {1'b0, cc_one};
    if (!f.is_cmp)
    begin
      case (fsc_pkg::fsc_kind_t'(f.kind))
        fsc_pkg::FSC_RC_NAN:  f.flags = fsc_pkg::FSC_QNAN;
        fsc_pkg::FSC_RC_INF:  f.flags = f.neg ? fsc_pkg::FSC_NINF
                                              : fsc_pkg::FSC_PINF;
        fsc_pkg::FSC_RC_NORM: f.flags = f.neg ? fsc_pkg::FSC_NNORM
                                              : fsc_pkg::FSC_PNORM;
        fsc_pkg::FSC_RC_DEN:  f.flags = f.neg ? fsc_pkg::FSC_NDENORM
                                              : fsc_pkg::FSC_PDENORM;
        fsc_pkg::FSC_RC_ZERO: f.flags = f.neg ? fsc_pkg::FSC_NZERO
                                              : fsc_pkg::FSC_PZERO;
        default:              f.flags = fsc_pkg::FSC_QNAN;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== core/fsc_status_ctrl.sv
`default_nettype none
module fsc_status_ctrl
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        fp_valid_i,
  input  wire logic        fp_upd_class_i,
  input  wire logic        fp_is_cmp_i,
  input  wire logic [3:0]  fp_cmp_cc_i,
  input  wire logic [2:0]  fp_kind_i,
  input  wire logic        fp_neg_i,
  input  wire logic [9:0]  fp_exc_i,
  input  wire logic        fp_fr_i,
  input  wire logic        fp_fi_i,
  input  wire logic        fp_upd_round_i,
  input  wire logic [2:0]  sw_op_i,
  input  wire logic [31:0] sw_data_i,
  input  wire logic [7:0]  sw_field_mask_i,
  input  wire logic [4:0]  sw_bit_i,
  input  wire logic        fp_exception_mode_hi_i,
  input  wire logic        fp_exception_mode_lo_i,
  output logic      [31:0] fp_status_control_o,
  output logic             assist_exc_o,
  output logic      [1:0]  rounding_control_o,
  output logic             non_ieee_mode_o
);
  // ----------------------------------------
  // condition vector
  // ----------------------------------------
  // fp_exc_i: 9 snan 8 isi 7 idi 6 zdz 5 imz 4 vc 3 cvi 2 sqrt
  //           1 zx 0 ox ; ux is held at 0 and xx comes from fp_fi_i gated by fp_upd_round_i
  logic [31:0] cond_mask;
  logic [31:0] ev_set;
  logic [31:0] r;
  logic [31:0] fp_status_control_r;
  logic [31:0] fp_status_control_nxt;
  logic        assist_exc_nxt;
  logic        en_hit;
  logic        any_vx;
  logic        mode_on;
  fsc_flag_if  fi ();

  assign fi.kind   = fp_kind_i;
  assign fi.neg    = fp_neg_i;
  assign fi.is_cmp = fp_is_cmp_i;
  assign fi.cmp_cc = fp_cmp_cc_i;

  fsc_flag_enc u_enc
  (
    .f (fi.enc)
  );

  // ----------------------------------------
  // next register value
  // ----------------------------------------
  always_comb
  begin
    cond_mask = 32'h0;
    ev_set    = 32'h0;
    cond_mask[fsc_pkg::OX_POS]   = 1'b1;
    cond_mask[fsc_pkg::UX_POS]   = 1'b1;
    cond_mask[fsc_pkg::ZX_POS]   = 1'b1;
    cond_mask[fsc_pkg::XX_POS]   = 1'b1;
    cond_mask[fsc_pkg::SNAN_POS] = 1'b1;
    cond_mask[fsc_pkg::ISI_POS]  = 1'b1;
    cond_mask[fsc_pkg::IDI_POS]  = 1'b1;
    cond_mask[fsc_pkg::ZDZ_POS]  = 1'b1;
    cond_mask[fsc_pkg::IMZ_POS]  = 1'b1;
    cond_mask[fsc_pkg::VC_POS]   = 1'b1;
    cond_mask[fsc_pkg::SOFT_POS] = 1'b1;
    cond_mask[fsc_pkg::SQRT_POS] = 1'b1;
    cond_mask[fsc_pkg::CVI_POS]  = 1'b1;
    if (fp_valid_i)
    begin
      ev_set[fsc_pkg::SNAN_POS] = fp_exc_i[9];
      ev_set[fsc_pkg::ISI_POS]  = fp_exc_i[8];
      ev_set[fsc_pkg::IDI_POS]  = fp_exc_i[7];
      ev_set[fsc_pkg::ZDZ_POS]  = fp_exc_i[6];
      ev_set[fsc_pkg::IMZ_POS]  = fp_exc_i[5];
      ev_set[fsc_pkg::VC_POS]   = fp_exc_i[4];
      ev_set[fsc_pkg::CVI_POS]  = fp_exc_i[3];
      ev_set[fsc_pkg::SQRT_POS] = fp_exc_i[2];
      ev_set[fsc_pkg::ZX_POS]   = fp_exc_i[1];
      ev_set[fsc_pkg::OX_POS]   = fp_exc_i[0];
      ev_set[fsc_pkg::UX_POS]   = fp_fr_i & 1'b0;
      ev_set[fsc_pkg::XX_POS]   = fp_fi_i & fp_upd_round_i;
    end
    r = fp_status_control_r;
    // software ops write first; hardware events then or in, so set wins
    case (fsc_pkg::fsc_swop_t'(sw_op_i))
      fsc_pkg::FSC_OP_MOVE:  r = sw_data_i;
      fsc_pkg::FSC_OP_FIELD:
      begin
        for (int i = 0; i < 8; i++)
          if (sw_field_mask_i[i])
            r[i*4 +: 4] = sw_data_i[i*4 +: 4];
      end
      fsc_pkg::FSC_OP_SETB:  r[5'd31 - sw_bit_i] = 1'b1;
      fsc_pkg::FSC_OP_CLRB:  r[5'd31 - sw_bit_i] = 1'b0;
      fsc_pkg::FSC_OP_CRF:   r = r & ~(cond_mask & sw_data_i);
      default:               r = fp_status_control_r;
    endcase
    if (fp_valid_i)
    begin
      if (fp_upd_class_i)
        r[fsc_pkg::FP_RESULT_FLAGS_LSB +: 5] = fi.flags;
      if (fp_upd_round_i)
      begin
        r[fsc_pkg::FR_POS] = fp_fr_i;
        r[fsc_pkg::FI_POS] = fp_fi_i;
      end
    end
    r = r | ev_set;
    // any-summary: new 0 to 1 on a condition bit
    if (|(r & ~fp_status_control_r & cond_mask))
      r[fsc_pkg::FX_POS] = 1'b1;
    any_vx = |(r & cond_mask & ~(32'h0 | (32'h1 << fsc_pkg::OX_POS)
             | (32'h1 << fsc_pkg::UX_POS) | (32'h1 << fsc_pkg::ZX_POS)
             | (32'h1 << fsc_pkg::XX_POS)));
    r[fsc_pkg::VX_POS] = any_vx;
    en_hit = (any_vx & r[fsc_pkg::VE_POS])
           | (r[fsc_pkg::OX_POS] & r[fsc_pkg::OE_POS])
           | (r[fsc_pkg::UX_POS] & r[fsc_pkg::UE_POS])
           | (r[fsc_pkg::ZX_POS] & r[fsc_pkg::ZE_POS])
           | (r[fsc_pkg::XX_POS] & r[fsc_pkg::XE_POS]);
    r[fsc_pkg::FEX_POS] = en_hit;
    r = r & ~fsc_pkg::RSVD_MASK;
    fp_status_control_nxt = r;
    mode_on = fp_exception_mode_hi_i | fp_exception_mode_lo_i;
    // trap on any condition newly raised by this instruction while some enabled condition is set
    assist_exc_nxt = fp_valid_i & mode_on
                   & |(ev_set & ~fp_status_control_r & {32{en_hit}});
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fp_status_control_r <= fsc_pkg::RESET_VAL;
    end
    else
    begin
      fp_status_control_r <= fp_status_control_nxt;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fp_status_control_o <= fsc_pkg::RESET_VAL;
      assist_exc_o        <= 1'b0;
      rounding_control_o  <= 2'h0;
      non_ieee_mode_o     <= 1'b0;
    end
    else
    begin
      fp_status_control_o <= fp_status_control_nxt;
      assist_exc_o        <= assist_exc_nxt;
      rounding_control_o  <=
        fp_status_control_nxt[fsc_pkg::RN_LSB +: 2];
      non_ieee_mode_o     <= fp_status_control_nxt[fsc_pkg::NI_POS];
    end
  end

endmodule
`default_nettype wire

// ===== shared/fsc_flag_if.sv
`default_nettype none
interface fsc_flag_if;
  logic [2:0] kind;
  logic       neg;
  logic       is_cmp;
  logic [3:0] cmp_cc;
  logic [4:0] flags;
  modport enc (input kind, input neg, input is_cmp, input cmp_cc,
               output flags);
  modport usr (output kind, output neg, output is_cmp, output cmp_cc,
               input flags);
endinterface
`default_nettype wire

// ===== shared/fsc_pkg.sv
`default_nettype none
package fsc_pkg;
  // bit positions use big-endian numbering: bit n sits at vector index 31-n
  localparam int unsigned FX_POS     = 31 - 0;
  localparam int unsigned FEX_POS    = 31 - 1;
  localparam int unsigned VX_POS     = 31 - 2;
  localparam int unsigned OX_POS     = 31 - 3;
  localparam int unsigned UX_POS     = 31 - 4;
  localparam int unsigned ZX_POS     = 31 - 5;
  localparam int unsigned XX_POS     = 31 - 6;
  localparam int unsigned SNAN_POS   = 31 - 7;
  localparam int unsigned ISI_POS    = 31 - 8;
  localparam int unsigned IDI_POS    = 31 - 9;
  localparam int unsigned ZDZ_POS    = 31 - 10;
  localparam int unsigned IMZ_POS    = 31 - 11;
  localparam int unsigned VC_POS     = 31 - 12;
  localparam int unsigned FR_POS     = 31 - 13;
  localparam int unsigned FI_POS     = 31 - 14;
  localparam int unsigned FP_RESULT_FLAGS_LSB   = 31 - 19;
  localparam int unsigned RSVD_POS   = 31 - 20;
  localparam int unsigned SOFT_POS   = 31 - 21;
  localparam int unsigned SQRT_POS   = 31 - 22;
  localparam int unsigned CVI_POS    = 31 - 23;
  localparam int unsigned VE_POS     = 31 - 24;
  localparam int unsigned OE_POS     = 31 - 25;
  localparam int unsigned UE_POS     = 31 - 26;
  localparam int unsigned ZE_POS     = 31 - 27;
  localparam int unsigned XE_POS     = 31 - 28;
  localparam int unsigned NI_POS     = 31 - 29;
  localparam int unsigned RN_LSB     = 31 - 31;
  localparam logic [31:0] RESET_VAL  = 32'h0000_0000;
  localparam logic [31:0] RSVD_MASK  = 32'h0000_0800;

  typedef enum logic [4:0] {
    FSC_QNAN    = 5'h11,
    FSC_NINF    = 5'h09,
    FSC_NNORM   = 5'h08,
    FSC_NDENORM = 5'h18,
    FSC_NZERO   = 5'h12,
    FSC_PZERO   = 5'h02,
    FSC_PDENORM = 5'h14,
    FSC_PNORM   = 5'h04,
    FSC_PINF    = 5'h05
  } fsc_rclass_t;

  typedef enum logic [2:0] {
    FSC_RC_ZERO = 3'h0,
    FSC_RC_DEN  = 3'h1,
    FSC_RC_NORM = 3'h2,
    FSC_RC_INF  = 3'h3,
    FSC_RC_NAN  = 3'h4
  } fsc_kind_t;

  typedef enum logic [1:0] {
    FSC_RND_NEAR = 2'h0,
    FSC_RND_ZERO = 2'h1,
    FSC_RND_PINF = 2'h2,
    FSC_RND_NINF = 2'h3
  } fsc_round_t;

  typedef enum logic [2:0] {
    FSC_OP_NONE  = 3'h0,
    FSC_OP_MOVE  = 3'h1,
    FSC_OP_FIELD = 3'h2,
    FSC_OP_SETB  = 3'h3,
    FSC_OP_CLRB  = 3'h4,
    FSC_OP_CRF   = 3'h5
  } fsc_swop_t;
endpackage
`default_nettype wire

// ===== testbench/fsc_status_ctrl_checker.sv
`default_nettype none
module fsc_status_ctrl_checker
(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        fp_valid_i,
  input wire logic        fp_upd_class_i,
  input wire logic        fp_is_cmp_i,
  input wire logic [2:0]  sw_op_i,
  input wire logic        fp_exception_mode_hi_i,
  input wire logic        fp_exception_mode_lo_i,
  input wire logic [31:0] fp_status_control_o,
  input wire logic        assist_exc_o,
  input wire logic [1:0]  rounding_control_o,
  input wire logic        non_ieee_mode_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_no_sw;
    sw_op_i == 3'h0;
  endsequence
  sequence s_fp_op;
    fp_valid_i ##0 s_no_sw;
  endsequence
  property p_rsvd;
    !fp_status_control_o[11];
  endproperty
  property p_rnd;
    rounding_control_o == fp_status_control_o[1:0];
  endproperty
  property p_ni;
    non_ieee_mode_o == fp_status_control_o[2];
  endproperty
  property p_cmp;
    s_fp_op ##0 (fp_upd_class_i && fp_is_cmp_i)
      |=> $onehot(fp_status_control_o[15:12]);
  endproperty
  property p_soft;
    s_no_sw |=> $stable(fp_status_control_o[10]);
  endproperty
  property p_sqrt;
    fp_status_control_o[9] ##0 s_no_sw |=> fp_status_control_o[9];
  endproperty
  // fx follows a hardware-raised overflow in the same update
  property p_fx;
    s_fp_op ##1 $rose(fp_status_control_o[28]) |-> fp_status_control_o[31];
  endproperty
  property p_fex;
    fp_status_control_o[28] && fp_status_control_o[6]
      |-> fp_status_control_o[30];
  endproperty
  property p_mode0;
    !fp_exception_mode_hi_i && !fp_exception_mode_lo_i |=> !assist_exc_o;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_rnd: assert property (p_rnd) else $error("rounding out wrong");
  a_ni: assert property (p_ni) else $error("non ieee out wrong");
  a_cmp: assert property (p_cmp) else $error("cond code not onehot");
  a_soft: assert property (p_soft) else $error("soft bit moved");
  a_sqrt: assert property (p_sqrt) else $error("sqrt bit lost");
  a_fx: assert property (p_fx) else $error("any summary missing");
  a_fex: assert property (p_fex) else $error("enabled summary off");
  a_mode0: assert property (p_mode0) else $error("assist in mode 0");
endmodule
bind fsc_status_ctrl fsc_status_ctrl_checker u_chk (.*);
`default_nettype wire

// ===== testbench/tb_fp_status_control_flags.sv
`default_nettype none
module tb_fp_status_control_flags;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] m; logic [31:0] v; logic a;} fsc_note_t;
  logic        mclk_i, reset_i, fp_valid_i, fp_upd_class_i, fp_is_cmp_i;
  logic        fp_neg_i, fp_exception_mode_hi_i, fp_exception_mode_lo_i;
  logic        assist_exc_o, non_ieee_mode_o;
  logic [1:0]  rounding_control_o;
  logic [2:0]  fp_kind_i, sw_op_i;
  logic [3:0]  fp_cmp_cc_i, cc;
  logic [4:0]  sw_bit_i;
  logic [9:0]  fp_exc_i;
  logic [31:0] sw_data_i, fp_status_control_o, d;
  logic [2:0]  kd [9] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [4:0]  cd [9] = '{5'h11, 5'h09, 5'h08, 5'h18, 5'h12, 5'h02, 5'h14,
                          5'h04, 5'h05};
  logic [4:0]  pi [10] = '{5'd28, 5'd26, 5'd9, 5'd8, 5'd19, 5'd20, 5'd21,
                           5'd22, 5'd23, 5'd24};
  fsc_note_t   q[$];
  fsc_note_t   n_r;
  int          bad_count, total_checks, cyc;

  // rounded/inexact and field writes are left untested for length
  fsc_status_ctrl dut (.*, .fp_fr_i(1'b0), .fp_fi_i(1'b0),
    .fp_upd_round_i(1'b0), .sw_field_mask_i(8'h00));

  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic go(logic [31:0] m, logic [31:0] v, logic a);
    q.push_back('{m, v, a});
    @(posedge mclk_i);
    fp_valid_i <= 1'b0;
    sw_op_i <= 3'h0;
    {fp_exception_mode_hi_i, fp_exception_mode_lo_i} <= 2'h0;
    @(posedge mclk_i);
  endtask
  task automatic mv(logic [31:0] dt, logic [31:0] m, logic [31:0] v);
    sw_op_i <= 3'h1;
    sw_data_i <= dt;
    go(m, v, 1'b0);
  endtask
  task automatic sb(logic [2:0] o, logic [4:0] b, logic [31:0] m,
                    logic [31:0] v);
    sw_op_i <= o;
    sw_bit_i <= b;
    go(m, v, 1'b0);
  endtask
  task automatic fp(logic c, logic [3:0] k4, logic [2:0] k, logic n,
                    logic [9:0] e, logic [31:0] m, logic [31:0] v, logic a);
    fp_valid_i <= 1'b1;
    fp_upd_class_i <= 1'b1;
    fp_is_cmp_i <= c;
    fp_cmp_cc_i <= k4;
    fp_kind_i <= k;
    fp_neg_i <= n;
    fp_exc_i <= e;
    go(m, v, a);
  endtask
  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  always @(posedge mclk_i)
    if (!reset_i && (fp_valid_i || sw_op_i != 3'h0))
    begin
      #1;
      n_r = q.pop_front();
      chk("status", n_r.v, fp_status_control_o & n_r.m);
      chk("assist", {31'h0, n_r.a}, {31'h0, assist_exc_o});
    end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {reset_i, fp_valid_i, fp_upd_class_i, fp_is_cmp_i, fp_neg_i} = 5'h10;
    {fp_exception_mode_hi_i, fp_exception_mode_lo_i} = 2'h0;
    {fp_kind_i, sw_op_i, fp_cmp_cc_i, sw_bit_i, fp_exc_i} = 25'h0;
    sw_data_i = 32'h0;
    void'($urandom(32'ha32abe7b));
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    chk("reset", 32'h0, fp_status_control_o);
    for (int i = 0; i < 9; i++)
      fp(1'b0, 4'h0, kd[i], (i == 0) ? 1'($urandom) : (i < 5), 10'h0,
         32'h1f000, {15'h0, cd[i], 12'h0}, 1'b0);
    $display("test class done");
    for (int i = 0; i < 5; i++)
    begin
      cc = (i < 4) ? 4'h8 >> i : 4'h6;
      fp(1'b1, cc, 3'h0, 1'b0, 10'h0, 32'hf000,
         {16'h0, (i < 4) ? cc : 4'h1, 12'h0}, 1'b0);
    end
    $display("test compare done");
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      d[1:0] = 2'(i);
      mv(d, 32'hfff, d & 32'h7ff);
      chk("rounding", 32'(i), {30'h0, rounding_control_o});
      chk("non_ieee", {31'h0, d[2]}, {31'h0, non_ieee_mode_o});
    end
    mv(32'h0, 32'hffff_ffff, 32'h0);
    sb(3'h3, 5'd21, 32'h400, 32'h400);
    fp(1'b0, 4'h0, 3'h2, 1'b0, 10'h004, 32'h600, 32'h600, 1'b0);
    fp(1'b0, 4'h0, 3'h2, 1'b0, 10'h0, 32'h600, 32'h600, 1'b0);
    sb(3'h4, 5'd21, 32'h600, 32'h200);
    sb(3'h4, 5'd22, 32'h200, 32'h0);
    $display("test sticky done");
    for (int j = 0; j < 10; j++)
      for (int e = 0; e < 2; e++)
        for (int md = 0; md < 4; md++)
        begin
          d = e ? 32'hf8 : 32'h0;
          mv(d, 32'hff, d);
          {fp_exception_mode_hi_i, fp_exception_mode_lo_i} <= 2'(md);
          fp(1'b0, 4'h0, 3'h2, 1'b0, 10'(1 << j),
             32'hc000_0000 | (32'h1 << pi[j]),
             32'h8000_0000 | (32'h1 << pi[j]) | (d << 27),
             e != 0 && md != 0);
        end
    $display("test assist done");
    repeat (3) @(posedge mclk_i);
    stop_test();
  end
endmodule
`default_nettype wire
